// *** core/ulrp_consts.vh ***
// Constants for the ULPI register and status-byte port.
// Included by the design files; definitions only.
`ifndef ULRP_CONSTS_VH
`define ULRP_CONSTS_VH

// ==========================================
// Command classes, bits 7:6 of the command byte
`define ULRP_CLS_IDLE 2'h0
`define ULRP_CLS_TX 2'h1
`define ULRP_CLS_WR 2'h2
`define ULRP_CLS_RD 2'h3
`define ULRP_IDLE_BYTE 8'h00
`define ULRP_CLS_HI 7
`define ULRP_CLS_LO 6
`define ULRP_ADDR_HI 5
`define ULRP_PID_HI 3
`define ULRP_NOPID 6'h00

// ==========================================
// Register addresses
`define ULRP_ADDR_DEBUG 6'h15
`define ULRP_ADDR_SCR_WR 6'h16
`define ULRP_ADDR_SCR_SET 6'h17
`define ULRP_ADDR_SCR_CLR 6'h18
`define ULRP_SCR_RESET 8'h00

// ==========================================
// Status byte encodings
`define ULRP_VB_END 2'h0
`define ULRP_VB_LOW 2'h1
`define ULRP_VB_SESS 2'h2
`define ULRP_VB_VALID 2'h3
`define ULRP_RX_IDLE 2'h0
`define ULRP_RX_ACT 2'h1
`define ULRP_RX_DISC 2'h2
`define ULRP_RX_ERR 2'h3

`endif

// *** core/ulrp_port.v ***
// ULPI-side protocol logic: command decode, register handshakes, status bytes.
// Assumes the link shares mclk and keeps the ULPI protocol on its side.
//
// How it works
// RULE_01: Debug register bits 1:0 mirror line state, upper bits read zero.
// RULE_02: Scratch byte resets to zero; write 16h, set 17h, clear 18h, readable.
// RULE_03: Link never touches vendor 30h-3Fh, carkit or extended registers.
// RULE_04: Link waits for bus direction low before issuing register commands.
// RULE_05: Command bits 7:6 select idle, transmit, register write, register read.
// RULE_06: Transmit low field zero means no PID, else bits 3:0 hold PID.
// RULE_07: Register commands carry a six-bit address in bits 5:0.
// RULE_08: Write: command, next high, data, idle with stop, next low.
// RULE_09: Direction stays low in a write; data commits after stop falls.
// RULE_10: After a write the link drives idle byte onto the bus.
// RULE_11: Read: next accepts command, direction up, turnaround, data, direction down.
// RULE_12: Link samples read data, then drives idle after the turnaround.
// RULE_13: Status bytes only while owning the bus, on comparator or interrupt events; the code also sends one after every transmit stop.
// RULE_14: Line state change with bus idle makes the PHY send a status byte.
// RULE_15: During receive, status bytes go out whenever direction high, next low.
// RULE_16: During transmit, status bytes wait until the link raises stop.
// RULE_17: Status bits 1:0 carry line state bits 1:0 directly.
// RULE_18: Status bits 3:2 encode the VBUS comparator levels.
// RULE_19: Status bits 5:4 encode receive active, error and host disconnect.
// RULE_20: Status bit 6 carries the ID pin level.
// RULE_21: Comparator rising edge with its enable set raises an interrupt event.
// RULE_22: Status bit 7 is always zero.
`timescale 1ns/1ps
`include "ulrp_consts.vh"

module ulrp_port (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // ULPI bus, data is a two-way pin
  input wire [7:0] dataIn,
  output reg [7:0] dataOut,
  output reg dataOe,
  output reg dir,
  output reg nxt,
  input wire stp,
  // Analogue and receiver status
  input wire [1:0] lineState,
  input wire sessEnd,
  input wire sessValid,
  input wire vbusValid,
  input wire idPin,
  input wire rxActive,
  input wire rxError,
  input wire hostDisconnect,
  input wire [4:0] riseEnable,
  // Receive data path from the USB receiver
  input wire rxByteValid,
  input wire [7:0] rxByte,
  // Transmit command decode toward the transmitter
  output reg txStart,
  output reg txNoPid,
  output reg [3:0] txPid
);

  // ==========================================
  // States
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_WR_ACK = 4'h1;
  localparam [3:0] ST_WR_DATA = 4'h2;
  localparam [3:0] ST_WR_STOP = 4'h3;
  localparam [3:0] ST_RD_ACK = 4'h4;
  localparam [3:0] ST_RD_TURN = 4'h5;
  localparam [3:0] ST_RD_DATA = 4'h6;
  localparam [3:0] ST_TX = 4'h7;
  localparam [3:0] ST_ST_TURN = 4'h8;
  localparam [3:0] ST_ST_SEND = 4'h9;
  localparam [3:0] ST_RX = 4'ha;
  localparam [3:0] ST_BACK = 4'hb;

  reg [3:0] state;
  reg [5:0] regAddr;
  reg [7:0] wrByte;
  reg wrEn;
  reg [1:0] lastLine;
  reg [4:0] lastComp;
  reg stPending;
  reg wasRx;
  wire [7:0] rdData;
  wire [4:0] comp;
  wire [7:0] statusByte;
  wire lineChange;
  wire compChange;
  wire riseEvent;
  wire [1:0] cmdCls;

  // ==========================================
  // Command byte fields
  function [1:0] cmdClass;
    input [7:0] cmd;
    begin
      cmdClass = cmd[`ULRP_CLS_HI:`ULRP_CLS_LO]; // RULE_05
    end
  endfunction

  function [5:0] cmdAddr;
    input [7:0] cmd;
    begin
      cmdAddr = cmd[`ULRP_ADDR_HI:0]; // RULE_07
    end
  endfunction

  function [3:0] cmdPid;
    input [7:0] cmd;
    begin
      cmdPid = cmd[`ULRP_PID_HI:0]; // RULE_06
    end
  endfunction

  assign cmdCls = cmdClass(dataIn);

  // ==========================================
  // Status byte encoding
  function [1:0] vbusCode;
    input sEnd;
    input sVld;
    input vVld;
    begin
      if (vVld) begin
        vbusCode = `ULRP_VB_VALID; // RULE_18
      end else if (sVld) begin
        vbusCode = `ULRP_VB_SESS; // RULE_18
      end else if (sEnd) begin
        vbusCode = `ULRP_VB_END; // RULE_18
      end else begin
        vbusCode = `ULRP_VB_LOW; // RULE_18
      end
    end
  endfunction

  function [1:0] rxCode;
    input act;
    input err;
    input disc;
    begin
      if (disc) begin
        rxCode = `ULRP_RX_DISC; // RULE_19
      end else if (act && err) begin
        rxCode = `ULRP_RX_ERR; // RULE_19
      end else if (act) begin
        rxCode = `ULRP_RX_ACT; // RULE_19
      end else begin
        rxCode = `ULRP_RX_IDLE; // RULE_19
      end
    end
  endfunction

  // Bit 7 reserved low, ID level, rx events, vbus, line state
  assign statusByte = {1'b0, idPin, rxCode(rxActive, rxError, hostDisconnect), // RULE_22 RULE_20
    vbusCode(sessEnd, sessValid, vbusValid), lineState}; // RULE_17

  // ==========================================
  // Event detection
  assign comp = {idPin, sessEnd, sessValid, vbusValid, hostDisconnect};
  assign lineChange = lineState != lastLine;
  assign compChange = comp != lastComp; // RULE_13
  assign riseEvent = |(comp & ~lastComp & riseEnable); // RULE_21

  always @(posedge mclk) begin
    if (!rst_b) begin
      // Start from the live levels, so leaving reset is not taken as an event
      lastLine <= lineState;
      lastComp <= comp;
    end else begin
      lastLine <= lineState;
      lastComp <= comp;
    end
  end

  // Pending status byte; a new event in the send cycle keeps it pending
  always @(posedge mclk) begin
    if (!rst_b) begin
      stPending <= 1'b0;
    end else if (lineChange || compChange || riseEvent) begin
      stPending <= 1'b1; // RULE_13 RULE_14
    end else if (state == ST_ST_SEND) begin
      stPending <= 1'b0;
    end
  end

  // ==========================================
  // Register store
  ulrp_regfile regs (
    .mclk(mclk),
    .rst_b(rst_b),
    .wrEn(wrEn),
    .wrAddr(regAddr),
    .wrData(wrByte),
    .rdAddr(regAddr),
    .lineState(lineState),
    .rdData(rdData)
  );

  // ==========================================
  // Protocol state machine
  always @(posedge mclk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      regAddr <= 6'h00;
      wrByte <= 8'h00;
      wrEn <= 1'b0;
      dataOut <= 8'h00;
      dataOe <= 1'b0;
      dir <= 1'b0;
      nxt <= 1'b0;
      txStart <= 1'b0;
      txNoPid <= 1'b0;
      txPid <= 4'h0;
      wasRx <= 1'b0;
    end else begin
      wrEn <= 1'b0;
      txStart <= 1'b0;
      case (state)
        ST_IDLE: begin
          dataOe <= 1'b0;
          if (rxActive) begin
            // Receive takes the bus; next with dir marks receive active
            dir <= 1'b1;
            nxt <= 1'b1;
            wasRx <= 1'b1;
            state <= ST_RX;
          end else if (cmdCls == `ULRP_CLS_WR) begin // RULE_05
            regAddr <= cmdAddr(dataIn); // RULE_07
            nxt <= 1'b1; // RULE_08
            state <= ST_WR_ACK;
          end else if (cmdCls == `ULRP_CLS_RD) begin // RULE_05
            regAddr <= cmdAddr(dataIn); // RULE_07
            nxt <= 1'b1; // RULE_11
            state <= ST_RD_ACK;
          end else if (cmdCls == `ULRP_CLS_TX) begin // RULE_05
            txNoPid <= cmdAddr(dataIn) == `ULRP_NOPID; // RULE_06
            txPid <= cmdPid(dataIn); // RULE_06
            txStart <= 1'b1;
            nxt <= 1'b1;
            state <= ST_TX;
          end else if (stPending) begin
            dir <= 1'b1; // RULE_14
            state <= ST_ST_TURN;
          end
        end
        // Link drives data in the cycle after next rises; dir stays low
        ST_WR_ACK: state <= ST_WR_DATA; // RULE_08 RULE_09
        // Stop arrives with the idle byte, so only the byte before it is data
        ST_WR_DATA: begin
          if (stp) begin
            nxt <= 1'b0; // RULE_08
            state <= ST_WR_STOP;
          end else begin
            wrByte <= dataIn; // RULE_08
          end
        end
        // Commit only once stop has fallen
        ST_WR_STOP: begin
          if (!stp) begin
            wrEn <= 1'b1; // RULE_09
            state <= ST_IDLE;
          end
        end
        ST_RD_ACK: begin
          dir <= 1'b1; // RULE_11
          nxt <= 1'b0; // RULE_11
          state <= ST_RD_TURN;
        end
        ST_RD_TURN: begin
          dataOe <= 1'b1;
          dataOut <= rdData; // RULE_11
          state <= ST_RD_DATA;
        end
        ST_RD_DATA: begin
          dataOe <= 1'b0;
          dir <= 1'b0; // RULE_11 RULE_12
          state <= ST_BACK;
        end
        // Status withheld until the link stops the transmit
        ST_TX: begin
          if (stp) begin
            nxt <= 1'b0;
            dir <= 1'b1; // RULE_16
            state <= ST_ST_TURN;
          end
        end
        ST_ST_TURN: begin
          dataOe <= 1'b1;
          dataOut <= statusByte;
          state <= ST_ST_SEND;
        end
        ST_ST_SEND: begin
          dataOe <= 1'b0;
          dir <= 1'b0;
          state <= ST_BACK;
        end
        ST_RX: begin
          dataOe <= 1'b1;
          if (!rxActive) begin
            dataOe <= 1'b0;
            dir <= 1'b0;
            nxt <= 1'b0;
            wasRx <= 1'b0;
            state <= ST_BACK;
          end else if (rxByteValid) begin
            nxt <= 1'b1;
            dataOut <= rxByte;
          end else begin
            nxt <= 1'b0; // RULE_15
            dataOut <= statusByte; // RULE_15
          end
        end
        // Turnaround cycle; link then drives idle
        ST_BACK: state <= ST_IDLE; // RULE_10 RULE_12
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // ulrp_port

// *** core/ulrp_regfile.v ***
// Register store of the ULPI port: debug mirror and scratch byte.
// Assumes one clock; writes are single-cycle strobes from the protocol logic.
`timescale 1ns/1ps
`include "ulrp_consts.vh"

module ulrp_regfile (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Access
  input wire wrEn,
  input wire [5:0] wrAddr,
  input wire [7:0] wrData,
  input wire [5:0] rdAddr,
  // Live line state
  input wire [1:0] lineState,
  // Registered read data
  output reg [7:0] rdData
);

  reg [7:0] scratch;

  // ==========================================
  // Scratch byte with write, set and clear aliases
  always @(posedge mclk) begin
    if (!rst_b) begin
      scratch <= `ULRP_SCR_RESET;
    end else if (wrEn) begin
      case (wrAddr)
        `ULRP_ADDR_SCR_WR: scratch <= wrData; // RULE_02
        `ULRP_ADDR_SCR_SET: scratch <= scratch | wrData; // RULE_02
        `ULRP_ADDR_SCR_CLR: scratch <= scratch & ~wrData; // RULE_02
        default: scratch <= scratch;
      endcase
    end
  end

  // ==========================================
  // Read mux; unmapped addresses read zero
  always @(posedge mclk) begin
    if (!rst_b) begin
      rdData <= 8'h00;
    end else begin
      case (rdAddr)
        `ULRP_ADDR_DEBUG: rdData <= {6'h00, lineState}; // RULE_01
        `ULRP_ADDR_SCR_WR, `ULRP_ADDR_SCR_SET, `ULRP_ADDR_SCR_CLR: rdData <= scratch; // RULE_02
        default: rdData <= 8'h00;
      endcase
    end
  end

endmodule // ulrp_regfile

// *** testbench/ulrp_link_model.sv ***
// Link controller partner: issues commands and collects PHY bytes.
// Assumes it shares mclk with the PHY; the bench calls its tasks.
`timescale 1ns/1ps
module ulrp_link_model (
  // Clock
  input wire mclk,
  // PHY side
  input wire [7:0] dataOut,
  input wire dataOe,
  input wire dir,
  input wire nxt,
  // Link side
  output wire [7:0] busIn,
  output reg stp
);
  reg [7:0] d = 8'h00;
  reg [7:0] last = 8'h00;
  reg [7:0] q[$];
  integer n;
  // ==========
  // Released bus shows the inverse of its last value, never a kind zero
  assign busIn = dataOe ? dataOut : !dir ? d : ~last;
  initial stp = 1'b0;
  always @(posedge mclk) begin
    last <= busIn;
    if (dir && dataOe)
      q.push_back(dataOut);
  end
  // ==========
  // Transfers
  task cmd(input [7:0] c);
    begin
      while (dir) begin
        @(posedge mclk);
        #1;
      end
      d = c;
      n = 0;
      @(posedge mclk);
      while (!nxt && n < 20) begin
        @(posedge mclk);
        n = n + 1;
      end
      #1;
    end
  endtask
  task wr(input [5:0] a, input [7:0] v);
    begin
      cmd({2'h2, a});
      d = v;
      @(posedge mclk);
      #1;
      d = 8'h00;
      stp = 1'b1;
      n = 0;
      @(posedge mclk);
      while (nxt && n < 20) begin
        @(posedge mclk);
        n = n + 1;
      end
      #1;
      stp = 1'b0;
    end
  endtask
  task rd(input [5:0] a, output [7:0] r);
    begin
      cmd({2'h3, a});
      d = 8'h00;
      q.delete();
      n = 0;
      while (q.size() == 0 && n < 20) begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      r = (q.size() > 0) ? q[$] : 8'hxx;
      while (dir) begin
        @(posedge mclk);
        #1;
      end
      // Leave the turnaround cycle alone before driving again
      @(posedge mclk);
      #1;
    end
  endtask
  task tx(input [3:0] p);
    begin
      cmd({4'h4, p});
      d = 8'h5a;
      @(posedge mclk);
      #1;
      d = 8'h00;
      stp = 1'b1;
      @(posedge mclk);
      #1;
      stp = 1'b0;
    end
  endtask
endmodule // ulrp_link_model

// *** testbench/ulrp_port_bench.sv ***
// Self-checking bench of the ULPI port against a behavioural model.
// Assumes the link partner model and the bound pin checker.
`timescale 1ns/1ps
module ulrp_port_bench;
  reg mclk = 1'b0;
  reg rst_b = 1'b0;
  reg [1:0] lineState = 2'h0;
  reg sessEnd = 1'b1;
  reg sessValid = 1'b0;
  reg vbusValid = 1'b0;
  reg idPin = 1'b0;
  reg rxActive = 1'b0;
  reg rxError = 1'b0;
  reg hostDisconnect = 1'b0;
  reg [4:0] riseEnable = 5'h1f;
  reg rxByteValid = 1'b0;
  reg [7:0] rxByte = 8'h00;
  wire [7:0] dataIn;
  wire [7:0] dataOut;
  wire dataOe, dir, nxt, stp, txStart, txNoPid;
  wire [3:0] txPid;
  reg [31:0] seed = 32'h00006271;
  reg [31:0] v;
  reg [7:0] b, m;
  reg [4:0] tp = 5'h00;
  integer txSeen = 0;
  integer fail_count = 0, checks = 0, j, k, t;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk)
    if (txStart === 1'b1) begin
      tp <= {txNoPid, txPid};
      txSeen <= txSeen + 1;
    end
  ulrp_port i_ulrp_port (.mclk(mclk), .rst_b(rst_b), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .dir(dir), .nxt(nxt), .stp(stp), .lineState(lineState), .sessEnd(sessEnd), .sessValid(sessValid),
    .vbusValid(vbusValid), .idPin(idPin), .rxActive(rxActive), .rxError(rxError),
    .hostDisconnect(hostDisconnect), .riseEnable(riseEnable), .rxByteValid(rxByteValid), .rxByte(rxByte),
    .txStart(txStart), .txNoPid(txNoPid), .txPid(txPid));
  ulrp_link_model i_ulrp_link_model (.mclk(mclk), .dataOut(dataOut), .dataOe(dataOe), .dir(dir), .nxt(nxt),
    .busIn(dataIn), .stp(stp));
  // ==========
  // Model and helpers
  function [31:0] rnd();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  function [7:0] stat();
    stat = {1'b0, idPin, hostDisconnect ? 2'h2 : {rxActive & rxError, rxActive},
      vbusValid ? 2'h3 : sessValid ? 2'h2 : sessEnd ? 2'h0 : 2'h1, lineState};
  endfunction
  task chk(input [7:0] g, input [7:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // Waits for a quiet bus so a late second status byte cannot pose as read data
  task getst(output [7:0] r);
    begin
      k = 0;
      t = 0;
      while (t < 4 && k < 60) begin
        @(posedge mclk);
        #1;
        t = (i_ulrp_link_model.q.size() > 0 && !dir) ? t + 1 : 0;
        k = k + 1;
      end
      r = (i_ulrp_link_model.q.size() > 0) ? i_ulrp_link_model.q[$] : 8'hxx;
      i_ulrp_link_model.q.delete();
    end
  endtask
  task wrap_up();
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #500000;
    fail_count = fail_count + 1;
    wrap_up();
  end
  // ==========
  // Tests
  initial begin
    repeat (5) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    i_ulrp_link_model.rd(6'h16, b);
    chk(b, 8'h00);
    for (j = 0; j < 3; j = j + 1) begin
      v = rnd();
      i_ulrp_link_model.wr(6'h16 + j, v[7:0]);
      m = (j == 0) ? v[7:0] : (j == 1) ? (m | v[7:0]) : (m & ~v[7:0]);
      for (k = 0; k < 3; k = k + 1) begin
        i_ulrp_link_model.rd(6'h16 + k, b);
        chk(b, m);
      end
    end
    i_ulrp_link_model.rd(6'h20, b);
    chk(b, 8'h00);
    i_ulrp_link_model.wr(6'h15, 8'hff);
    $display("register tests done");
    for (j = 0; j < 8; j = j + 1) begin
      v = rnd();
      lineState = lineState ^ (v[1:0] | 2'h1);
      {hostDisconnect, idPin, vbusValid, sessValid, sessEnd} = v[6:2];
      riseEnable = v[11:7];
      getst(b);
      chk(b, stat());
      i_ulrp_link_model.rd(6'h15, b);
      chk(b, {6'h00, lineState});
    end
    $display("status tests done");
    for (j = 0; j < 4; j = j + 1) begin
      m = txSeen;
      i_ulrp_link_model.tx(j * 5);
      getst(b);
      chk(b, stat());
      chk({3'h0, tp}, {3'h0, j == 0, 4'h0} | j * 5);
      chk(txSeen - m, 8'h01);
    end
    $display("transmit tests done");
    rxActive = 1'b1;
    @(posedge mclk);
    #1;
    for (j = 0; j < 6; j = j + 1) begin
      v = rnd();
      rxByteValid = v[0];
      rxByte = v[15:8];
      rxError = (j == 4);
      @(posedge mclk);
      #1;
      chk(dataOut, rxByteValid ? rxByte : stat());
      chk({5'h00, dir, nxt, dataOe}, {5'h00, 1'b1, rxByteValid, 1'b1});
    end
    {rxActive, rxError, rxByteValid} = 3'h0;
    getst(b);
    $display("receive test done");
    wrap_up();
  end
endmodule // ulrp_port_bench
bind ulrp_port ulrp_port_monitor i_ulrp_port_monitor (.mclk(mclk), .rst_b(rst_b), .dataIn(dataIn),
  .dataOut(dataOut), .dataOe(dataOe), .dir(dir), .nxt(nxt), .stp(stp), .lineState(lineState),
  .rxActive(rxActive), .txStart(txStart));

// *** testbench/ulrp_port_monitor.sv ***
// Pin checker of the ULPI register and status-byte port.
// Bound to ulrp_port; sees its ports only.
`timescale 1ns/1ps
module ulrp_port_monitor (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Pins
  input wire [7:0] dataIn,
  input wire [7:0] dataOut,
  input wire dataOe,
  input wire dir,
  input wire nxt,
  input wire stp,
  input wire [1:0] lineState,
  input wire rxActive,
  input wire txStart
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // ==========
  // Handshakes
  a_rst_quiet:
  assert property (disable iff (1'b0) !rst_b |=> !dir && !nxt && !dataOe && !txStart) else $error("busy in reset");
  a_wr_dir_low:
  assert property ($rose(nxt) && !dir && dataIn[7:6] == 2'h2 |-> !dir [*3]) else $error("dir rose in write");
  a_rd_turn:
  assert property ($rose(nxt) && !dir && dataIn[7:6] == 2'h3 |=> dir && !nxt ##1 dir && dataOe ##1 !dir)
    else $error("bad read turnaround");
  a_stp_nxt:
  assert property (nxt && !dir && stp |=> !nxt) else $error("nxt held after stp");
  a_tx_start:
  assert property ($rose(nxt) && !dir && dataIn[7:6] == 2'h1 |-> ##[0:2] txStart) else $error("no tx start");
  a_tx_once:
  assert property (txStart |=> !txStart) else $error("tx start too long");
  // ==========
  // Status bytes and receive takeover
  a_oe_own:
  assert property (dataOe |-> dir) else $error("drive without bus");
  a_bit7_zero:
  assert property (dataOe && !nxt && !$past(nxt, 2) |-> !dataOut[7]) else $error("status bit 7 set");
  a_ls_send:
  assert property ($changed(lineState) && !dir && !nxt && !stp |-> ##[1:8] dir) else $error("no line status");
  a_rx_take:
  assert property ($rose(rxActive) && !dir && !nxt |-> ##[1:4] dir && nxt) else $error("receive not taken");
endmodule // ulrp_port_monitor
